// ### rtl/acsb_pkg.sv
// constants and types for the amplifier control and status byte bank
package acsb_pkg;

    // -------------------------------------------------------------
    // byte counts and reset values
    // -------------------------------------------------------------
    localparam int         N_CTRL   = 3;
    localparam int         N_STAT   = 2;
    localparam logic [7:0] CB_RST   = 8'h00;
    localparam logic [7:0] SB_RST   = 8'h00;
    // bits with a defined function in each control byte
    localparam logic [7:0] CB1_USED = 8'hfb;
    localparam logic [7:0] CB2_USED = 8'hff;
    localparam logic [7:0] CB3_USED = 8'h9f;
    // status bits that survive a read
    localparam logic [7:0] SB1_KEEP = 8'h50;
    localparam logic [7:0] SB2_KEEP = 8'h10;

    // -------------------------------------------------------------
    // control byte field positions
    // -------------------------------------------------------------
    localparam int C1_OFFS_FAULT_INDICATOR_PIN = 7;
    localparam int C_OFFS_MON   = 6;
    localparam int C_CLIP_RPT   = 5;
    localparam int C1_FHOP      = 4;
    localparam int C1_TRIM      = 3;
    localparam int C_CH_DIS     = 1;
    localparam int C1_RUN       = 0;
    localparam int C2_OFFS_PROT = 7;
    localparam int C2_PREW_CLIP = 4;
    localparam int C2_PREW_SEL  = 3;
    localparam int C2_DCLD      = 2;
    localparam int C2_MUTE      = 0;
    localparam int C3_LATCH     = 7;
    localparam int C3_ACLD      = 4;
    localparam int C3_PH_HI     = 3;
    localparam int C3_PH_LO     = 1;
    localparam int C3_BDMOD     = 0;

    // -------------------------------------------------------------
    // status byte field positions
    // -------------------------------------------------------------
    localparam int S1_NOCTL = 7;
    localparam int S1_VALID = 6;
    localparam int S1_OVP   = 5;
    localparam int S2_OT    = 7;
    localparam int S2_PREW  = 6;
    localparam int S2_UVP   = 5;
    localparam int S_OPEN   = 4;
    localparam int S_SHORT  = 3;
    localparam int S1_OFFS  = 2;
    localparam int S_SUP    = 1;
    localparam int S_GND    = 0;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_RUN  = 2'b01,
        LD_DONE = 2'b11
    } acsb_ld_t;

    // events from the analog protection and diagnostic circuits
    typedef struct packed {
        logic       overvoltage_protection;
        logic       undervoltage_protection;
        logic       overtemp;
        logic       prewarn;
        logic [1:0] offs;
        logic [1:0] short_load;
        logic [1:0] short_sup;
        logic [1:0] short_gnd;
        logic [1:0] clip;
        logic [1:0] open_load;
        logic       ld_done;
        logic       ld_hang;
        logic       ac_hit;
        logic       out_start;
    } acsb_evt_t;

    // decoded controls towards the amplifier core
    typedef struct packed {
        logic       standby;
        logic       mute;
        logic [1:0] ch_en;
        logic       offs_fault_indicator_pin_en;
        logic       offs_prot_en;
        logic [1:0] offs_mon_en;
        logic       fhop_en;
        logic       trim_up;
        logic       prew_120;
        logic       dcld_start;
        logic       acld_en;
        logic [2:0] phase_sel;
        logic       bd_mod;
    } acsb_ctl_t;

endpackage

// ### rtl/acsb_sticky.sv
// one status byte of sticky flags, clear-on-read with set priority
`timescale 1ns/1ps
module acsb_sticky
    import acsb_pkg::*;
#(
    parameter int         WIDTH = 8,
    parameter logic [7:0] RST   = SB_RST
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flag_q
);
    logic [WIDTH-1:0] flag_d;

    // set wins over a clear in the same cycle so no event is lost
    always_comb begin
        flag_d = (flag_q & ~clr_i) | set_i;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= RST[WIDTH-1:0];
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule

// ### rtl/acsb_top.sv
// control and diagnostic byte bank of the two-channel amplifier
`timescale 1ns/1ps
module acsb_top
    import acsb_pkg::*;
#(
    parameter int PIN_W = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             xfer_start,
    input  wire logic             wr_valid,
    input  wire logic [7:0]       wr_byte,
    input  wire logic             rd_req,
    input  wire logic             parallel_mode,
    input  wire acsb_evt_t        evt,
    input  wire logic [PIN_W-1:0] addr_pin,
    input  wire logic [PIN_W-1:0] mode_pin,
    output logic      [7:0]       rd_byte,
    output logic                  rd_valid,
    output acsb_ctl_t             ctl,
    output logic                  fault_pin,
    output logic                  clip_pin,
    output logic      [PIN_W-1:0] addr_latched,
    output logic      [PIN_W-1:0] mode_latched
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       cb1;
        logic [7:0]       cb2;
        logic [7:0]       cb3;
        logic [1:0]       wr_idx;
        logic [1:0]       rd_idx;
        logic [7:0]       rd_byte;
        logic             rd_valid;
        acsb_ctl_t        ctl;
        logic             fault_pin;
        logic             clip_pin;
        logic [PIN_W-1:0] addr_l;
        logic [PIN_W-1:0] mode_l;
        acsb_ld_t         ld_st;
        logic             valid;
        logic [1:0]       open_l;
        logic             dcld_prev;
    } acsb_st_t;

    acsb_st_t   s_q;
    acsb_st_t   s_d;
    logic [7:0] sb1_set;
    logic [7:0] sb2_set;
    logic [7:0] sb1_clr;
    logic [7:0] sb2_clr;
    logic [7:0] sb1_q;
    logic [7:0] sb2_q;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic       no_ctl;
    logic [1:0] offs_hit;

    // -------------------------------------------------------------
    // sticky fault flags
    // -------------------------------------------------------------
    acsb_sticky #(.WIDTH(8), .RST(SB_RST)) u_sb1 (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .set_i   (sb1_set),
        .clr_i   (sb1_clr),
        .flag_q  (sb1_q)
    );

    acsb_sticky #(.WIDTH(8), .RST(SB_RST)) u_sb2 (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .set_i   (sb2_set),
        .clr_i   (sb2_clr),
        .flag_q  (sb2_q)
    );

    // -------------------------------------------------------------
    // status byte assembly
    // -------------------------------------------------------------
    always_comb begin
        no_ctl = (s_q.cb1 == CB_RST) && (s_q.cb2 == CB_RST) && (s_q.cb3 == CB_RST);
        offs_hit[0] = evt.offs[0] & ~s_q.cb1[C_OFFS_MON];
        offs_hit[1] = evt.offs[1] & ~s_q.cb2[C_OFFS_MON];
        sb1_set = 8'h00;
        sb2_set = 8'h00;
        // supply protection, temperature and offset latch into sticky flags
        sb1_set[S1_OVP]  = evt.overvoltage_protection;
        sb1_set[S1_OFFS] = |offs_hit;
        sb2_set[S2_OT]   = evt.overtemp;
        sb2_set[S2_PREW] = evt.prewarn;
        sb2_set[S2_UVP]  = evt.undervoltage_protection;
        // parallel mode folds channel two into byte one
        if (parallel_mode) begin
            sb1_set[S_SHORT] = |evt.short_load;
            sb1_set[S_SUP]   = |evt.short_sup;
            sb1_set[S_GND]   = |evt.short_gnd;
        end else begin
            sb1_set[S_SHORT] = evt.short_load[0];
            sb2_set[S_SHORT] = evt.short_load[1];
            // supply and ground shorts per channel
            sb1_set[S_SUP]   = evt.short_sup[0];
            sb2_set[S_SUP]   = evt.short_sup[1];
            sb1_set[S_GND]   = evt.short_gnd[0];
            sb2_set[S_GND]   = evt.short_gnd[1];
        end
        // a read clears the byte except the load result bits
        sb1_clr = (rd_req && s_q.rd_idx == 2'd0) ? ~SB1_KEEP : 8'h00;
        sb2_clr = (rd_req && s_q.rd_idx == 2'd1) ? ~SB2_KEEP : 8'h00;
        stat1   = sb1_q & ~SB1_KEEP;
        stat2   = sb2_q & ~SB2_KEEP;
        // valid bit of byte one and level flags of both bytes
        stat1[S1_NOCTL] = no_ctl;
        stat1[S1_VALID] = s_q.valid;
        stat1[S_OPEN]   = parallel_mode ? |s_q.open_l : s_q.open_l[0];
        stat2[S_OPEN]   = parallel_mode ? 1'b0 : s_q.open_l[1];
        // bit two of byte two is reserved
        stat2[S1_OFFS]  = 1'b0;
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.rd_valid = 1'b0;
        if (xfer_start) begin
            s_d.wr_idx = 2'd0;
            s_d.rd_idx = 2'd0;
        end
        // control bytes accepted in order, extras ignored
        if (wr_valid && s_q.wr_idx < 2'(N_CTRL)) begin
            case (s_q.wr_idx)
                2'd0: begin
                    s_d.cb1 = wr_byte;
                end
                2'd1: begin
                    s_d.cb2 = wr_byte;
                end
                default: begin
                    s_d.cb3 = wr_byte;
                end
            endcase
            s_d.wr_idx = s_q.wr_idx + 2'd1;
        end
        // status one first, then status two
        if (rd_req) begin
            s_d.rd_valid = 1'b1;
            case (s_q.rd_idx)
                2'd0: begin
                    s_d.rd_byte = stat1;
                end
                2'd1: begin
                    s_d.rd_byte = stat2;
                end
                default: begin
                    s_d.rd_byte = 8'h00;
                end
            endcase
            if (s_q.rd_idx < 2'(N_STAT)) begin
                s_d.rd_idx = s_q.rd_idx + 2'd1;
            end
        end

        s_d.ctl.standby      = ~s_d.cb1[C1_RUN];
        s_d.ctl.mute         = s_d.cb1[C1_RUN] & s_d.cb2[C2_MUTE];
        // channel disable bits and modulation type
        s_d.ctl.ch_en        = {~s_d.cb2[C_CH_DIS], ~s_d.cb1[C_CH_DIS]};
        s_d.ctl.bd_mod       = s_d.cb3[C3_BDMOD];
        s_d.ctl.offs_fault_indicator_pin_en = ~s_d.cb1[C1_OFFS_FAULT_INDICATOR_PIN];
        s_d.ctl.offs_prot_en = ~s_d.cb2[C2_OFFS_PROT];
        s_d.ctl.offs_mon_en  = {~s_d.cb2[C_OFFS_MON], ~s_d.cb1[C_OFFS_MON]};
        s_d.ctl.fhop_en      = s_d.cb1[C1_FHOP];
        s_d.ctl.trim_up      = s_d.cb1[C1_TRIM];
        s_d.ctl.prew_120     = s_d.cb2[C2_PREW_SEL];
        s_d.ctl.acld_en      = s_d.cb3[C3_ACLD];
        // phase code passes through; codes 110 and 111 are undefined
        s_d.ctl.phase_sel    = s_d.cb3[C3_PH_HI:C3_PH_LO];

        // fault pin follows no-control bit and gated offset
        s_d.fault_pin = no_ctl | (sb1_q[S1_OFFS] & ~s_q.cb1[C1_OFFS_FAULT_INDICATOR_PIN]);
        // clip per channel, pre-warning, AC hit
        s_d.clip_pin  = (evt.clip[0] & ~s_q.cb1[C_CLIP_RPT])
                      | (evt.clip[1] & ~s_q.cb2[C_CLIP_RPT])
                      | (evt.prewarn & ~s_q.cb2[C2_PREW_CLIP])
                      | (evt.ac_hit & s_q.cb3[C3_ACLD]);

        if (s_q.cb3[C3_LATCH] || (evt.out_start && !s_q.cb3[C3_LATCH])) begin
            s_d.addr_l = addr_pin;
            s_d.mode_l = mode_pin;
        end

        s_d.dcld_prev = s_q.cb2[C2_DCLD];
        case (s_q.ld_st)
            LD_IDLE: begin
                // restart only when both channels are disabled as the enable rises
                if (s_q.cb2[C2_DCLD] && !s_q.dcld_prev
                    && s_q.cb1[C_CH_DIS] && s_q.cb2[C_CH_DIS]) begin
                    s_d.ld_st = LD_RUN;
                end
            end
            LD_RUN: begin
                // abort by supply protection or hang-up
                if (evt.undervoltage_protection || evt.overvoltage_protection || evt.ld_hang) begin
                    s_d.valid = 1'b0;
                    s_d.ld_st = LD_DONE;
                end else if (evt.ld_done) begin
                    s_d.valid  = 1'b1;
                    s_d.open_l = evt.open_load;
                    s_d.ld_st  = LD_DONE;
                end else if (!s_q.cb2[C2_DCLD]) begin
                    s_d.ld_st = LD_IDLE;
                end
            end
            LD_DONE: begin
                // clearing the enable releases a hang-up
                if (!s_q.cb2[C2_DCLD]) begin
                    s_d.ld_st = LD_IDLE;
                end
            end
            default: begin
                s_d.ld_st = LD_IDLE;
            end
        endcase
        s_d.ctl.dcld_start = (s_d.ld_st == LD_RUN);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.cb1       <= CB_RST;
            s_q.cb2       <= CB_RST;
            s_q.cb3       <= CB_RST;
            s_q.ld_st     <= LD_IDLE;
            s_q.ctl       <= '0;
            s_q.ctl.standby <= 1'b1;
            s_q.ctl.ch_en   <= 2'b11;
            s_q.ctl.offs_fault_indicator_pin_en <= 1'b1;
            s_q.ctl.offs_prot_en <= 1'b1;
            s_q.ctl.offs_mon_en  <= 2'b11;
            s_q.fault_pin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign rd_byte      = s_q.rd_byte;
    assign rd_valid     = s_q.rd_valid;
    assign ctl          = s_q.ctl;
    assign fault_pin    = s_q.fault_pin;
    assign clip_pin     = s_q.clip_pin;
    assign addr_latched = s_q.addr_l;
    assign mode_latched = s_q.mode_l;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    chk_wr_first: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_valid && !xfer_start && s_q.wr_idx == 2'd0 |=> s_q.cb1 == $past(wr_byte))
        else $error("first written byte not stored as control byte one");

    chk_rd_second: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_req && !xfer_start && s_q.rd_idx == 2'd1 |=> rd_valid && rd_byte == $past(stat2))
        else $error("second read byte is not status byte two");

    chk_noctl_bit: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_req && !xfer_start && s_q.rd_idx == 2'd0 && no_ctl |=> rd_byte[S1_NOCTL])
        else $error("no-control bit missing with all controls zero");

    chk_fault_pin: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        no_ctl |=> fault_pin)
        else $error("fault pin low while no-control bit set");

    chk_flag_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        sb1_q[S_GND] && !(rd_req && s_q.rd_idx == 2'd0) |=> sb1_q[S_GND])
        else $error("ground short flag dropped without a read");

    chk_read_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_req && s_q.rd_idx == 2'd0 && sb1_set == 8'h00 |=> (sb1_q & ~SB1_KEEP) == 8'h00)
        else $error("status byte one not cleared by read");

    chk_keep_open: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.ld_st != LD_RUN |=> $stable(s_q.open_l) && $stable(s_q.valid))
        else $error("load result changed outside detection");

    chk_ld_abort: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_q.ld_st == LD_RUN && (evt.undervoltage_protection || evt.overvoltage_protection || evt.ld_hang) |=> !s_q.valid ##1 !s_q.valid)
        else $error("valid bit survived an aborted detection");

    chk_standby: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_valid && !xfer_start && s_q.wr_idx == 2'd0 && !wr_byte[C1_RUN] |=> ctl.standby)
        else $error("standby not entered");

    chk_clip_ch1: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        evt.clip[0] && !s_q.cb1[C_CLIP_RPT] |=> clip_pin)
        else $error("channel one clip not reported");
endmodule

// ### tb/acsb_host.sv
// host model: issues control writes and status reads on the byte bank
`timescale 1ns/1ps
module acsb_host
    import acsb_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_byte,
    input  wire logic       rd_valid,
    output logic            xfer_start,
    output logic            wr_valid,
    output logic      [7:0] wr_byte,
    output logic            rd_req
);
    logic [7:0] rd_data [4];
    logic       hang;
    logic [7:0] used [4];

    initial begin
        xfer_start = 1'b0;
        wr_valid   = 1'b0;
        wr_byte    = 8'h00;
        rd_req     = 1'b0;
        hang       = 1'b0;
        used       = '{CB1_USED, CB2_USED, CB3_USED, 8'hff};
    end

    task automatic begin_xfer();
        @(posedge ref_clk);
        xfer_start <= 1'b1;
        @(posedge ref_clk);
        xfer_start <= 1'b0;
    endtask

    // bytes in order, undefined bits zero
    task automatic write_bytes(input int n, input logic [7:0] b [4]);
        begin_xfer();
        for (int i = 0; i < n; i++) begin
            wr_valid <= 1'b1;
            wr_byte  <= b[i] & used[i];
            @(posedge ref_clk);
        end
        wr_valid <= 1'b0;
        // released data shows the inverse, never a stale byte
        wr_byte  <= ~wr_byte;
    endtask

    task automatic read_bytes(input int n);
        int k;
        begin_xfer();
        for (int i = 0; i < n; i++) begin
            rd_req <= 1'b1;
            @(posedge ref_clk);
            rd_req <= 1'b0;
            k = 0;
            do begin
                @(posedge ref_clk);
                k++;
            end while (rd_valid !== 1'b1 && k < 4);
            hang = hang | (rd_valid !== 1'b1);
            rd_data[i] = rd_byte;
        end
    endtask
endmodule

// ### tb/tb_acsb_top.sv
// self-checking bench for the amplifier control and status byte bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_acsb_top
    import acsb_pkg::*;
;
    logic             ref_clk;
    logic             rst_n;
    logic             xfer_start;
    logic             wr_valid;
    logic      [7:0]  wr_byte;
    logic             rd_req;
    logic             parallel_mode;
    acsb_evt_t        evt;
    logic      [2:0]  addr_pin;
    logic      [2:0]  mode_pin;
    logic      [7:0]  rd_byte;
    logic             rd_valid;
    acsb_ctl_t        ctl;
    logic             fault_pin;
    logic             clip_pin;
    logic      [2:0]  addr_latched;
    logic      [2:0]  mode_latched;
    int               n_mismatch;
    int               samples_checked;
    logic      [7:0]  wb [4];
    logic      [2:0]  ph;

    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    acsb_top #(.PIN_W(3)) acsb_top_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .xfer_start(xfer_start), .wr_valid(wr_valid),
        .wr_byte(wr_byte), .rd_req(rd_req), .parallel_mode(parallel_mode), .evt(evt),
        .addr_pin(addr_pin), .mode_pin(mode_pin), .rd_byte(rd_byte), .rd_valid(rd_valid),
        .ctl(ctl), .fault_pin(fault_pin), .clip_pin(clip_pin),
        .addr_latched(addr_latched), .mode_latched(mode_latched)
    );

    acsb_host acsb_host_inst (
        .ref_clk(ref_clk), .rd_byte(rd_byte), .rd_valid(rd_valid), .xfer_start(xfer_start),
        .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr3(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        wb = '{c1, c2, c3, 8'h00};
        acsb_host_inst.write_bytes(3, wb);
        wt(2);
    endtask

    task automatic rd(input int n);
        acsb_host_inst.read_bytes(n);
        if (acsb_host_inst.hang) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    task automatic pulse(input acsb_evt_t p);
        @(posedge ref_clk);
        evt <= p;
        @(posedge ref_clk);
        evt <= '0;
        wt(3);
    endtask

    // events held as levels while the controls change under them
    task automatic clip_row(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
                            input acsb_evt_t p, input logic x);
        @(posedge ref_clk);
        evt <= p;
        wr3(c1, c2, c3);
        `CHK("clip pin", x, clip_pin)
    endtask

    function automatic acsb_ctl_t exp_ctl(input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] c3);
        acsb_ctl_t x;
        x = '0;
        x.standby      = ~c1[0];
        x.mute         = c1[0] & c2[0];
        x.ch_en        = ~{c2[1], c1[1]};
        x.offs_fault_indicator_pin_en = ~c1[7];
        x.offs_prot_en = ~c2[7];
        x.offs_mon_en  = ~{c2[6], c1[6]};
        x.fhop_en      = c1[4];
        x.trim_up      = c1[3];
        x.prew_120     = c2[3];
        x.acld_en      = c3[4];
        x.phase_sel    = c3[3:1];
        x.bd_mod       = c3[0];
        return x;
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        parallel_mode = 1'b0;
        evt = '0;
        addr_pin = 3'h0;
        mode_pin = 3'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        wt(1);
        `CHK("reset ctl", exp_ctl(8'h00, 8'h00, 8'h00), ctl)
        `CHK("reset fault", 1'b1, fault_pin)
        rd(2);
        `CHK("status1 idle", 8'h80, acsb_host_inst.rd_data[0])
        `CHK("status2 idle", 8'h00, acsb_host_inst.rd_data[1])
        // phase codes 000 to 101, other fields flipped between passes
        for (int p = 0; p < 6; p++) begin
            ph = 3'(p);
            @(posedge ref_clk);
            addr_pin <= ph;
            mode_pin <= ~ph;
            wr3(ph[0] ? 8'hfb : 8'h01, ph[0] ? 8'hfb : 8'h00, {ph[0], 2'b00, ~ph[0], ph, ph[1]});
            `CHK("ctl decode", exp_ctl(wb[0], wb[1], wb[2]), ctl)
            `CHK("fault off", 1'b0, fault_pin)
            if (ph[0]) `CHK("addr now", ph, addr_latched)
            if (ph[0]) `CHK("mode now", ~ph, mode_latched)
        end
        wr3(8'h01, 8'h00, 8'h00);
        @(posedge ref_clk);
        addr_pin <= 3'h6;
        mode_pin <= 3'h1;
        wt(3);
        `CHK("addr held", 3'h5, addr_latched)
        pulse('{out_start: 1'b1, default: '0});
        `CHK("addr switch", 3'h6, addr_latched)
        `CHK("mode switch", 3'h1, mode_latched)
        pulse('{overvoltage_protection: 1'b1, undervoltage_protection: 1'b1, overtemp: 1'b1, prewarn: 1'b1, offs: 2'b01,
                short_load: 2'b10, short_sup: 2'b01, short_gnd: 2'b10, default: '0});
        wt(4);
        `CHK("offset fault", 1'b1, fault_pin)
        rd(3);
        `CHK("flags s1", 8'h26, acsb_host_inst.rd_data[0])
        `CHK("flags s2", 8'he9, acsb_host_inst.rd_data[1])
        `CHK("third read", 8'h00, acsb_host_inst.rd_data[2])
        wt(2);
        `CHK("fault cleared", 1'b0, fault_pin)
        rd(2);
        `CHK("cleared s1", 8'h00, acsb_host_inst.rd_data[0])
        `CHK("cleared s2", 8'h00, acsb_host_inst.rd_data[1])
        // offset latched but kept off the fault pin, then not monitored on channel one
        wr3(8'h81, 8'h00, 8'h00);
        pulse('{offs: 2'b01, default: '0});
        `CHK("offset no pin", 1'b0, fault_pin)
        rd(2);
        `CHK("offset flag", 8'h04, acsb_host_inst.rd_data[0])
        wr3(8'h41, 8'h00, 8'h00);
        pulse('{offs: 2'b01, default: '0});
        rd(2);
        `CHK("offset unmonitored", 8'h00, acsb_host_inst.rd_data[0])
        clip_row(8'h01, 8'h10, 8'h00, '{clip: 2'b01, default: '0}, 1'b1);
        clip_row(8'h21, 8'h10, 8'h00, '{clip: 2'b01, default: '0}, 1'b0);
        clip_row(8'h21, 8'h30, 8'h00, '{clip: 2'b10, default: '0}, 1'b0);
        clip_row(8'h21, 8'h10, 8'h00, '{clip: 2'b10, default: '0}, 1'b1);
        clip_row(8'h21, 8'h30, 8'h10, '{ac_hit: 1'b1, default: '0}, 1'b1);
        clip_row(8'h21, 8'h30, 8'h00, '{ac_hit: 1'b1, default: '0}, 1'b0);
        clip_row(8'h21, 8'h30, 8'h00, '{prewarn: 1'b1, default: '0}, 1'b0);
        clip_row(8'h21, 8'h20, 8'h00, '{prewarn: 1'b1, default: '0}, 1'b1);
        clip_row(8'h21, 8'h30, 8'h00, '0, 1'b0);
        rd(2);
        // dc load run with both channels disabled
        wr3(8'h03, 8'h06, 8'h00);
        `CHK("load start", 1'b1, ctl.dcld_start)
        pulse('{ld_done: 1'b1, open_load: 2'b10, default: '0});
        `CHK("load finished", 1'b0, ctl.dcld_start)
        for (int r = 0; r < 2; r++) begin
            rd(2);
            `CHK("load s1", 8'h40, acsb_host_inst.rd_data[0])
            `CHK("load s2", 8'h10, acsb_host_inst.rd_data[1])
        end
        // host drops the enable, then restarts detection
        wr3(8'h03, 8'h02, 8'h00);
        wr3(8'h03, 8'h06, 8'h00);
        `CHK("load restart", 1'b1, ctl.dcld_start)
        pulse('{undervoltage_protection: 1'b1, default: '0});
        rd(2);
        `CHK("valid dropped", 1'b0, acsb_host_inst.rd_data[0][6])
        `CHK("uvp flag", 1'b1, acsb_host_inst.rd_data[1][5])
        wr3(8'h03, 8'h02, 8'h00);
        @(posedge ref_clk);
        parallel_mode <= 1'b1;
        pulse('{short_gnd: 2'b10, default: '0});
        rd(2);
        `CHK("parallel s1", 1'b1, acsb_host_inst.rd_data[0][0])
        @(posedge ref_clk);
        parallel_mode <= 1'b0;
        wb = '{8'h01, 8'h00, 8'h00, 8'h5a};
        acsb_host_inst.write_bytes(4, wb);
        wt(2);
        `CHK("fourth byte", exp_ctl(8'h01, 8'h00, 8'h00), ctl)
        wr3(8'h00, 8'h00, 8'h00);
        `CHK("zero fault", 1'b1, fault_pin)
        rd(2);
        `CHK("zero s1", 8'h80, acsb_host_inst.rd_data[0])
        // a second reset in mid-run brings back the no-control state
        wr3(8'h01, 8'h00, 8'h00);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wt(1);
        `CHK("rerun ctl", exp_ctl(8'h00, 8'h00, 8'h00), ctl)
        `CHK("rerun fault", 1'b1, fault_pin)
        `CHK("rerun rd byte", 8'h00, rd_byte)
        stop_test();
    end
endmodule
